// ===== verilog/gpio_od_pkg.sv
// Constants and carrier types for the open-drain and alternate function port block
package gpio_od_pkg;
  localparam int          NUM_PORTS    = 4;
  localparam int          PORT_WIDTH   = 8;
  localparam logic [1:0]  PORT_A       = 2'h0;
  localparam logic [1:0]  PORT_B       = 2'h1;
  localparam logic [1:0]  PORT_C       = 2'h2;
  localparam logic [1:0]  PORT_D       = 2'h3;
  // Subregister indices written to the port address register
  localparam logic [7:0]  IDX_ALT_EN   = 8'h02;
  localparam logic [7:0]  IDX_OPEN_DRN = 8'h03;
  localparam logic [7:0]  IDX_AFS_ONE  = 8'h07;
  localparam logic [7:0]  IDX_AFS_TWO  = 8'h08;
  // Reset values
  localparam logic [7:0]  RST_ADDR     = 8'h00;
  localparam logic [7:0]  RST_OPEN_DRN = 8'h00;
  localparam logic [7:0]  RST_ALT_EN   = 8'h00;
  localparam logic [7:0]  RST_AFS      = 8'h00;
  // Port C selection bit positions and the port D reset bit
  localparam int          PC_ANALOG_IN_FOUR_BIT  = 0;
  localparam int          PC_ANALOG_IN_FIVE_BIT  = 1;
  localparam int          PC_ANALOG_IN_SIX_BIT  = 2;
  localparam int          PC_COMPARATOR_RESULT_OUT_BIT  = 3;
  localparam int          PD_RESET_BIT = 0;

  // Output request for one pin: level and drive enable
  typedef struct packed {
    logic val;
    logic en;
  } pin_req_t;

  // Register access strobes from the core
  typedef struct packed {
    logic [1:0] port;
    logic       addr_wr;
    logic       ctl_wr;
    logic       ctl_rd;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ===== verilog/pin_driver.sv
// Pin driver for one pin with open-drain control
`timescale 1ns/1ps
module pin_driver (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire gpio_od_pkg::pin_req_t req,
  input  wire logic                 open_drain,
  output logic                      pin_out,
  output logic                      pin_oe
);
  // Registered driver; open drain only ever pulls low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (open_drain) begin
      pin_out <= 1'b0;                   // R9
      pin_oe  <= req.en & ~req.val;      // R2 R9
    end else begin
      pin_out <= req.val;
      pin_oe  <= req.en;
    end
  end

  // Checks on the driver
  never_drive_high_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
    open_drain |=> !(pin_oe && pin_out))
    else $error("open-drain pin driven high");
  od_pull_low_a: assert property (@(posedge sys_clk) disable iff (rst) // R9
    (open_drain && req.en && !req.val) |=> (pin_oe && !pin_out))
    else $error("open-drain pin not pulled low");
  od_release_a: assert property (@(posedge sys_clk) disable iff (rst) // R9
    (open_drain && req.val) |=> !pin_oe)
    else $error("open-drain pin not released");
  push_pull_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!open_drain && req.en) |=> (pin_oe && pin_out == $past(req.val)))
    else $error("push-pull pin wrong");
endmodule

// ===== verilog/port_drain_altfunc.sv
// Port open-drain and alternate function selection, reached by indexed subregisters
`timescale 1ns/1ps
// Summary of operation
// R1 - Index 03H routes control accesses to open-drain
// R2 - Open-drain bit set never drives pin high
// R3 - Open-drain also applies to alternate function outputs
// R4 - Open-drain works independent of alternate enable
// R5 - Port A and D0 enable selects sole function
// R6 - Ports B, C keep unused second choice register
// R7 - Port C choice bits select analog, comparator
// R8 - D0 defaults to reset input function
// R9 - Open-drain pulls low or releases pin
module port_drain_altfunc (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire gpio_od_pkg::reg_req_t bus,
  output logic [7:0]                 rdata_q,
  input  wire logic [3:0][7:0]       port_val,
  input  wire logic [3:0][7:0]       port_en,
  input  wire logic [3:0][7:0]       alt_val,
  input  wire logic [3:0][7:0]       alt_en,
  output logic [3:0][7:0]            pin_out,
  output logic [3:0][7:0]            pin_oe,
  output logic                       analog_in_four_sel,
  output logic                       analog_in_five_sel,
  output logic                       analog_in_six_sel,
  output logic                       comparator_result_out_sel,
  output logic                       portd_pin0_reset_sel
);
  logic [3:0][7:0] addr_q;
  logic [3:0][7:0] od_q;
  logic [3:0][7:0] afen_q;
  logic [3:0][7:0] altfunc_choice_reg_one_q;
  logic [3:0][7:0] altfunc_choice_reg_two_q;
  logic [3:0][7:0] alt_act;
  logic [7:0]      rdata_d;
  logic [7:0]      cur_idx;

  // True when the port carries the choice registers
  function automatic logic has_choice(input logic [1:0] p);
    has_choice = (p == gpio_od_pkg::PORT_B) || (p == gpio_od_pkg::PORT_C); // R5 R6
  endfunction

  // Write strobe for one subregister of the selected port
  function automatic logic sub_wr(input gpio_od_pkg::reg_req_t b, input logic [7:0] idx,
                                  input logic [7:0] want);
    sub_wr = b.ctl_wr && (idx == want);
  endfunction

  assign cur_idx = addr_q[bus.port];

  // Port address registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_q <= {4{gpio_od_pkg::RST_ADDR}};
    end else if (bus.addr_wr) begin
      addr_q[bus.port] <= bus.wdata;
    end
  end

  // Open-drain subregisters
  // Only index 03H reaches the drain bits; other indices leave them alone
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      od_q <= {4{gpio_od_pkg::RST_OPEN_DRN}};
    end else if (sub_wr(bus, cur_idx, gpio_od_pkg::IDX_OPEN_DRN)) begin
      od_q[bus.port] <= bus.wdata;       // R1
    end
  end

  // Alternate function enable subregisters
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      afen_q <= {4{gpio_od_pkg::RST_ALT_EN}};
    end else if (sub_wr(bus, cur_idx, gpio_od_pkg::IDX_ALT_EN)) begin
      afen_q[bus.port] <= bus.wdata;
    end
  end

  // Choice registers exist only on ports B and C
  // Writes on ports A and D are dropped, so their choice indices read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      altfunc_choice_reg_one_q <= {4{gpio_od_pkg::RST_AFS}};
      altfunc_choice_reg_two_q <= {4{gpio_od_pkg::RST_AFS}};
    end else if (has_choice(bus.port)) begin
      if (sub_wr(bus, cur_idx, gpio_od_pkg::IDX_AFS_ONE)) begin
        altfunc_choice_reg_one_q[bus.port] <= bus.wdata;
      end
      if (sub_wr(bus, cur_idx, gpio_od_pkg::IDX_AFS_TWO)) begin
        altfunc_choice_reg_two_q[bus.port] <= bus.wdata;   // R6
      end
    end
  end

  // Read mux, unknown index reads zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (cur_idx)
      gpio_od_pkg::IDX_OPEN_DRN: rdata_d = od_q[bus.port];  // R1
      gpio_od_pkg::IDX_ALT_EN:   rdata_d = afen_q[bus.port];
      gpio_od_pkg::IDX_AFS_ONE:  rdata_d = altfunc_choice_reg_one_q[bus.port];
      gpio_od_pkg::IDX_AFS_TWO:  rdata_d = altfunc_choice_reg_two_q[bus.port];
      default:                   rdata_d = 8'h00;
    endcase
  end

  // Read data captured on the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (bus.ctl_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // Which pins carry an alternate function
  always_comb begin
    alt_act = afen_q;                                         // R5
    alt_act[gpio_od_pkg::PORT_C] = 8'h00;
    alt_act[gpio_od_pkg::PORT_C][gpio_od_pkg::PC_ANALOG_IN_FOUR_BIT] =
      afen_q[2][gpio_od_pkg::PC_ANALOG_IN_FOUR_BIT] & altfunc_choice_reg_one_q[2][gpio_od_pkg::PC_ANALOG_IN_FOUR_BIT]; // R7
    alt_act[gpio_od_pkg::PORT_C][gpio_od_pkg::PC_ANALOG_IN_FIVE_BIT] =
      afen_q[2][gpio_od_pkg::PC_ANALOG_IN_FIVE_BIT] & altfunc_choice_reg_one_q[2][gpio_od_pkg::PC_ANALOG_IN_FIVE_BIT]; // R7
    alt_act[gpio_od_pkg::PORT_C][gpio_od_pkg::PC_ANALOG_IN_SIX_BIT] =
      afen_q[2][gpio_od_pkg::PC_ANALOG_IN_SIX_BIT] & altfunc_choice_reg_one_q[2][gpio_od_pkg::PC_ANALOG_IN_SIX_BIT]; // R7
    alt_act[gpio_od_pkg::PORT_C][gpio_od_pkg::PC_COMPARATOR_RESULT_OUT_BIT] =
      afen_q[2][gpio_od_pkg::PC_COMPARATOR_RESULT_OUT_BIT] & ~altfunc_choice_reg_one_q[2][gpio_od_pkg::PC_COMPARATOR_RESULT_OUT_BIT]; // R7
  end

  // Selection outputs to the analog, comparator and reset logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      analog_in_four_sel        <= 1'b0;
      analog_in_five_sel        <= 1'b0;
      analog_in_six_sel         <= 1'b0;
      comparator_result_out_sel <= 1'b0;
      portd_pin0_reset_sel      <= 1'b1;                      // R8
    end else begin
      analog_in_four_sel        <= alt_act[2][gpio_od_pkg::PC_ANALOG_IN_FOUR_BIT];
      analog_in_five_sel        <= alt_act[2][gpio_od_pkg::PC_ANALOG_IN_FIVE_BIT];
      analog_in_six_sel         <= alt_act[2][gpio_od_pkg::PC_ANALOG_IN_SIX_BIT];
      comparator_result_out_sel <= alt_act[2][gpio_od_pkg::PC_COMPARATOR_RESULT_OUT_BIT];
      // D0 sole alternate is the reset input itself, so it stays selected
      portd_pin0_reset_sel      <= ~afen_q[3][gpio_od_pkg::PD_RESET_BIT] ? 1'b1
                                   : alt_act[3][gpio_od_pkg::PD_RESET_BIT]; // R5 R8
    end
  end

  // One driver per pin; open-drain acts after the function mux
  for (genvar p = 0; p < gpio_od_pkg::NUM_PORTS; p++) begin : g_port
    for (genvar i = 0; i < gpio_od_pkg::PORT_WIDTH; i++) begin : g_pin
      gpio_od_pkg::pin_req_t req;
      // One assign for the whole struct so the request has a single driver
      assign req = alt_act[p][i] ? {alt_val[p][i], alt_en[p][i]}          // R3
                                 : {port_val[p][i], port_en[p][i]};       // R3
      pin_driver u_drv (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .req        (req),
        .open_drain (od_q[p][i]),                             // R2 R4
        .pin_out    (pin_out[p][i]),
        .pin_oe     (pin_oe[p][i])
      );
    end
  end

  // Checks on register routing and selection
  od_write_route_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    (bus.ctl_wr && cur_idx == 8'h03) |=> (od_q[$past(bus.port)] == $past(bus.wdata)))
    else $error("open-drain write not routed");
  od_read_route_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    (bus.ctl_rd && cur_idx == 8'h03) |=> (rdata_q == $past(od_q[bus.port])))
    else $error("open-drain read wrong");
  alt_od_drive_a: assert property (@(posedge sys_clk) disable iff (rst) // R3
    (afen_q[0][0] && od_q[0][0] && alt_en[0][0] && alt_val[0][0]) |=> !pin_oe[0][0])
    else $error("alternate output drove open-drain pin");
  od_no_alt_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
    (!afen_q[1][0] && od_q[1][0]) |=> !(pin_oe[1][0] && pin_out[1][0]))
    else $error("open-drain ignored without alternate");
  porta_choice_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
    (bus.ctl_wr && bus.port == 2'h0 && cur_idx == 8'h07) |=> altfunc_choice_reg_one_q[0] == 8'h00)
    else $error("port A choice register written");
  comparator_result_out_select_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
    comparator_result_out_sel == $past(afen_q[2][3] && !altfunc_choice_reg_one_q[2][3]))
    else $error("comparator output select wrong");
  afs_two_ignored_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
    analog_in_four_sel == $past(afen_q[2][0] && altfunc_choice_reg_one_q[2][0]))
    else $error("analog select uses wrong bits");
  d0_reset_def_a: assert property (@(posedge sys_clk) // R8
    rst |=> portd_pin0_reset_sel)
    else $error("pin D0 not reset function after reset");

  // Routing, retention and per-pin function checks
  addr_route_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    bus.addr_wr |=> (addr_q[$past(bus.port)] == $past(bus.wdata)))
    else $error("port address write lost");
  od_keep_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    (bus.ctl_wr && cur_idx != gpio_od_pkg::IDX_OPEN_DRN) |=> $stable(od_q))
    else $error("open-drain changed by other index");
  rd_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    !bus.ctl_rd |=> $stable(rdata_q))
    else $error("read data changed without read");
  portd_choice_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
    (bus.ctl_wr && bus.port == gpio_od_pkg::PORT_D && cur_idx == gpio_od_pkg::IDX_AFS_ONE)
    |=> (altfunc_choice_reg_one_q[gpio_od_pkg::PORT_D] == 8'h00))
    else $error("port D choice register written");
  d0_alt_drive_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
    (afen_q[3][0] && !od_q[3][0] && alt_en[3][0])
    |=> (pin_oe[3][0] && pin_out[3][0] == $past(alt_val[3][0])))
    else $error("pin D0 alternate output not driven");
  afs_two_unused_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
    (bus.ctl_wr && cur_idx == gpio_od_pkg::IDX_AFS_TWO) |=> $stable(alt_act))
    else $error("second choice register changed selection");
  pc_reserved_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
    (afen_q[2][4] && !od_q[2][4]) |=> (pin_oe[2][4] == $past(port_en[2][4])))
    else $error("reserved port C pin not plain output");
  od_set_c: cover property (@(posedge sys_clk) disable iff (rst)
    bus.ctl_wr && cur_idx == 8'h03 && bus.wdata != 8'h00);
  comparator_result_out_on_c: cover property (@(posedge sys_clk) disable iff (rst) comparator_result_out_sel);
  ana_on_c: cover property (@(posedge sys_clk) disable iff (rst) analog_in_six_sel);
  afs_two_wr_c: cover property (@(posedge sys_clk) disable iff (rst)
    bus.ctl_wr && cur_idx == gpio_od_pkg::IDX_AFS_TWO);
  od_alt_c: cover property (@(posedge sys_clk) disable iff (rst)
    (od_q[0] & afen_q[0]) != 8'h00);
endmodule

// ===== tb/port_drain_altfunc_bench.sv
// Self-checking bench for the open-drain and alternate function port block
`timescale 1ns/1ps
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module port_drain_altfunc_bench;
  logic                  sys_clk;
  logic                  rst;
  gpio_od_pkg::reg_req_t bus;
  logic [7:0]            rdata_q;
  logic [7:0]            d;
  logic [3:0][7:0]       port_val, port_en, alt_val, alt_en, pin_out, pin_oe;
  logic [3:0][7:0]       od_m, ae_m;
  logic [7:0]            c1_m;
  logic [3:0]            sel_exp;
  logic                  sel_four, sel_five, sel_six, sel_comparator_result_out, sel_rst;
  int                    err_count, cmp_count;
  logic [7:0]            codes [5] = '{8'h00, 8'h07, 8'h08, 8'h0F, 8'hF0};

  port_drain_altfunc uut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata_q(rdata_q),
    .port_val(port_val), .port_en(port_en), .alt_val(alt_val), .alt_en(alt_en),
    .pin_out(pin_out), .pin_oe(pin_oe), .analog_in_four_sel(sel_four),
    .analog_in_five_sel(sel_five), .analog_in_six_sel(sel_six),
    .comparator_result_out_sel(sel_comparator_result_out), .portd_pin0_reset_sel(sel_rst));

  // Free-running system clock
  always #10 sys_clk = ~sys_clk;

  // One edge, then settle past it
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // Index write then control write; mirror the stored subregisters
  task automatic sub_wr(input logic [1:0] p, input logic [7:0] idx, input logic [7:0] v);
    bus.port = p;
    bus.addr_wr = 1'b1;
    bus.wdata = idx;
    tick();
    bus.addr_wr = 1'b0;
    bus.ctl_wr = 1'b1;
    bus.wdata = v;
    tick();
    bus.ctl_wr = 1'b0;
    if (idx === gpio_od_pkg::IDX_OPEN_DRN) od_m[p] = v;
    if (idx === gpio_od_pkg::IDX_ALT_EN) ae_m[p] = v;
    if (idx === gpio_od_pkg::IDX_AFS_ONE && p === gpio_od_pkg::PORT_C) c1_m = v;
  endtask

  // Index write then control read; data lands one edge later
  task automatic sub_rd(input logic [1:0] p, input logic [7:0] idx);
    bus.port = p;
    bus.addr_wr = 1'b1;
    bus.wdata = idx;
    tick();
    bus.addr_wr = 1'b0;
    bus.ctl_rd = 1'b1;
    tick();
    bus.ctl_rd = 1'b0;
    d = rdata_q;
  endtask

  // Expected pins after the mux and the drain control, every port
  task automatic check_pins();
    logic [7:0] s, v, e, oe;
    tick();
    for (int p = 0; p < 4; p++) begin
      s = ae_m[p];
      if (p == 2) s = ae_m[p] & {4'h0, ~c1_m[3], c1_m[2:0]};
      v = (s & alt_val[p]) | (~s & port_val[p]);
      e = (s & alt_en[p]) | (~s & port_en[p]);
      oe = e & ~(od_m[p] & v);
      `CHK(pin_oe[p], oe)
      `CHK(pin_out[p] & oe, v & ~od_m[p] & oe)
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    bus = '0;
    {port_val, port_en} = {32'h3C5A_96F0, 32'hFF0F_F0FF};
    {alt_val, alt_en} = {32'hA5C3_0F69, 32'h0FFF_3CF0};
    {od_m, ae_m, c1_m} = '0;
    repeat (10) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    // Reset values and plain outputs
    for (int p = 0; p < 4; p++) begin
      sub_rd(2'(p), gpio_od_pkg::IDX_OPEN_DRN);
      `CHK(d, 8'h00)
    end
    `CHK(sel_rst, 1'b1)
    check_pins();
    // Open-drain pattern per port, read back
    for (int p = 0; p < 4; p++) begin
      sub_wr(2'(p), gpio_od_pkg::IDX_OPEN_DRN, 8'h55 ^ 8'(p * 17));
      sub_rd(2'(p), gpio_od_pkg::IDX_OPEN_DRN);
      `CHK(d, 8'h55 ^ 8'(p * 17))
    end
    check_pins();
    // Unlisted index leaves the drain setting alone
    sub_wr(gpio_od_pkg::PORT_A, 8'h05, 8'hAA);
    sub_rd(gpio_od_pkg::PORT_A, gpio_od_pkg::IDX_OPEN_DRN);
    `CHK(d, 8'h55)
    // Alternate outputs under open drain
    for (int p = 0; p < 4; p++) sub_wr(2'(p), gpio_od_pkg::IDX_ALT_EN, 8'hF0 | 8'(p));
    check_pins();
    // Ports A and D have no choice register
    for (int p = 0; p < 4; p += 3) begin
      sub_wr(2'(p), gpio_od_pkg::IDX_AFS_ONE, 8'hFF);
      sub_rd(2'(p), gpio_od_pkg::IDX_AFS_ONE);
      `CHK(d, 8'h00)
    end
    // Second choice register stored but not used
    sub_wr(gpio_od_pkg::PORT_B, gpio_od_pkg::IDX_AFS_TWO, 8'hA5);
    sub_rd(gpio_od_pkg::PORT_B, gpio_od_pkg::IDX_AFS_TWO);
    `CHK(d, 8'hA5)
    check_pins();
    // Port C choice codes
    sub_wr(gpio_od_pkg::PORT_C, gpio_od_pkg::IDX_ALT_EN, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      sub_wr(gpio_od_pkg::PORT_C, gpio_od_pkg::IDX_AFS_ONE, codes[i]);
      check_pins();
      sel_exp = {codes[i][0], codes[i][1], codes[i][2], ~codes[i][3]};
      `CHK({sel_four, sel_five, sel_six, sel_comparator_result_out}, sel_exp)
    end
    // Drains disabled again
    for (int p = 0; p < 4; p++) sub_wr(2'(p), gpio_od_pkg::IDX_OPEN_DRN, 8'h00);
    check_pins();
    `CHK(sel_rst, 1'b1)
    finish_test();
  end
endmodule
